// ---- src/ltc_regs.sv ----
//
// Contract
// R1: power enable bits gate their blocks
// R2: bit 7 enables forward path
// R3: bit 6 enables feedback and phase shifter
// R4: shared oscillator is bit7 or bit6
// R5: bits 5..2 enable bias, filter, amps
// R6: bit 1 selects open loop
// R7: bit 0 selects error amp gain reduction
// R8: every register has a read-back address
// R9: phase code is code times 11.25 degrees
// R10: host writes zero to phase reserved bits
// R11: reset command clears all registers
// R12: forward code is code times 2.5dB
// R13: host writes zero to gain reserved bits
// R14: feedback code 11101 is 0dB, down 1dB/step
// R15: forward byte is gain upper half
// R16: feedback byte is gain lower half
// R17: host zeroes byte register reserved bits; the bench leaves forward byte bit 7 random
// R18: transaction is address then data bytes
// R19: sample rising serial clock, msb first
// R20: reset code, pin, power-on share state
// R21: 16-bit write commits after both bytes
`timescale 1ns/100ps
module ltc_regs
	import ltc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        serial_clk,
	input  wire logic        chip_select_n,
	input  wire logic        command_data_in,
	output logic             reply_data_out,
	output logic             reply_data_oe,
	output logic             forward_path_enable,
	output logic             feedback_path_enable,
	output logic             phase_shifter_enable,
	output logic             local_osc_enable,
	output logic             bias_enable,
	output logic             filter_amp_enable,
	output logic             input_amp_enable,
	output logic             error_amp_enable,
	output logic             open_loop_mode,
	output logic             error_amp_gain_reduce,
	output logic [4:0]       phase_shift_code,
	output logic [3:0]       forward_atten_code,
	output logic [4:0]       feedback_atten_code
);
	// ==========================================================
	// link domain: serial shifter on serial_clk
	// ==========================================================
	// frame reset: chip select high clears the shifter, framing and reply registers asynchronously,
	// so nothing depends on clock edges outside a frame
	logic       link_rst;
	logic [2:0] bit_cnt;
	logic [4:0] byte_cnt;
	logic [7:0] shift_in;
	logic [7:0] link_addr;
	logic [7:0] link_byte0;
	logic [7:0] link_byte1;
	logic       ev_toggle;
	logic [7:0] ev_addr;
	logic [15:0] ev_data;
	logic [1:0] ev_len;
	logic [7:0] out_shift;
	logic [15:0] rb_snapshot;

	assign link_rst = rst | chip_select_n;

	// R19: rising edge msb first
	always_ff @(posedge serial_clk or posedge link_rst) begin
		if (link_rst) begin
			bit_cnt  <= 3'h0;
			shift_in <= 8'h00;
		end else begin
			bit_cnt  <= bit_cnt + 3'h1;
			shift_in <= {shift_in[6:0], command_data_in};
		end
	end

	// R18: byte framing
	always_ff @(posedge serial_clk or posedge link_rst) begin
		if (link_rst) begin
			byte_cnt   <= 5'h00;
			link_addr  <= 8'h00;
			link_byte0 <= 8'h00;
			link_byte1 <= 8'h00;
		end else if (bit_cnt == 3'h7) begin
			if (byte_cnt != 5'h1f)
				byte_cnt <= byte_cnt + 5'h01;
			case (byte_cnt)
				5'h00:   link_addr  <= {shift_in[6:0], command_data_in};
				5'h01:   link_byte0 <= {shift_in[6:0], command_data_in};
				5'h02:   link_byte1 <= {shift_in[6:0], command_data_in};
				default: link_byte1 <= link_byte1;
			endcase
		end
	end

	// event to core: latched word stays stable while the toggle crosses
	// R21: gain commits after second byte
	always_ff @(posedge serial_clk or posedge rst) begin
		if (rst) begin
			ev_toggle <= 1'b0;
			ev_addr   <= 8'h00;
			ev_data   <= 16'h0000;
			ev_len    <= 2'h0;
		end else if (!chip_select_n && bit_cnt == 3'h7) begin
			if (byte_cnt == 5'h00 && {shift_in[6:0], command_data_in} == ADDR_RESET) begin
				ev_toggle <= ~ev_toggle;
				ev_addr   <= ADDR_RESET;
				ev_len    <= 2'h0;
			end else if (byte_cnt == 5'h01 && link_addr != ADDR_GAIN) begin
				ev_toggle <= ~ev_toggle;
				ev_addr   <= link_addr;
				ev_data   <= {8'h00, shift_in[6:0], command_data_in};
				ev_len    <= 2'h1;
			end else if (byte_cnt == 5'h02 && link_addr == ADDR_GAIN) begin
				ev_toggle <= ~ev_toggle;
				ev_addr   <= link_addr;
				ev_data   <= {link_byte0, shift_in[6:0], command_data_in};
				ev_len    <= 2'h2;
			end
		end
	end

	// registers seen from the link: core values are quasi-static between
	// writes, so a two-stage copy is adequate for read-back
	logic [7:0]  core_general;
	logic [7:0]  core_phase;
	logic [15:0] core_gain;
	logic [31:0] rb_sync1;
	logic [31:0] rb_sync2;
	always_ff @(posedge serial_clk or posedge rst) begin
		if (rst) begin
			rb_sync1 <= 32'h00000000;
			rb_sync2 <= 32'h00000000;
		end else begin
			rb_sync1 <= {core_general, core_phase, core_gain};
			rb_sync2 <= rb_sync1;
		end
	end

	// read-back select for a given address
	function automatic logic [15:0] rb_select(input logic [7:0] a, input logic [31:0] r);
		case (a)
			ADDR_GENERAL_RB:  rb_select = {r[31:24], 8'h00};
			ADDR_PHASE_RB:    rb_select = {r[23:16], 8'h00};
			ADDR_GAIN_RB:     rb_select = r[15:0];
			ADDR_FORWARD_RB:  rb_select = {r[15:8], 8'h00};
			ADDR_FEEDBACK_RB: rb_select = {r[7:0], 8'h00};
			default:          rb_select = 16'h0000;
		endcase
	endfunction : rb_select

	// selected read-back word, so each half is taken by an explicit slice
	logic [15:0] rb_now;
	assign rb_now = rb_select(link_addr, rb_sync2);

	// R8: reply shifter, falling edge drive
	always_ff @(negedge serial_clk or posedge link_rst) begin
		if (link_rst) begin
			out_shift     <= 8'h00;
			rb_snapshot   <= 16'h0000;
			reply_data_oe <= 1'b0;
		end else if (bit_cnt == 3'h0 && byte_cnt == 5'h01) begin
			rb_snapshot   <= rb_now;
			out_shift     <= rb_now[15:8];
			reply_data_oe <= (link_addr[7:4] == 4'hf);
		end else if (bit_cnt == 3'h0 && byte_cnt == 5'h02) begin
			out_shift <= rb_snapshot[7:0];
		end else begin
			out_shift <= {out_shift[6:0], 1'b0};
		end
	end
	assign reply_data_out = out_shift[7];

	// ==========================================================
	// core domain
	// ==========================================================
	// toggle synchroniser; stage one is read only by stage two
	logic tog_s1;
	logic tog_s2;
	logic tog_s3;
	logic ev_pulse;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tog_s1 <= 1'b0;
			tog_s2 <= 1'b0;
			tog_s3 <= 1'b0;
		end else begin
			tog_s1 <= ev_toggle;
			tog_s2 <= tog_s1;
			tog_s3 <= tog_s2;
		end
	end
	assign ev_pulse = tog_s2 ^ tog_s3;

	// R11: reset command clears all
	// R20: pin reset same state
	// R15: forward byte upper half
	// R16: feedback byte lower half
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			core_general <= GENERAL_RESET;
			core_phase   <= PHASE_RESET;
			core_gain    <= GAIN_RESET;
		end else if (ev_pulse) begin
			case (ev_addr)
				ADDR_RESET: begin
					core_general <= GENERAL_RESET;
					core_phase   <= PHASE_RESET;
					core_gain    <= GAIN_RESET;
				end
				ADDR_GENERAL:       core_general    <= ev_data[7:0];
				ADDR_PHASE:         core_phase      <= ev_data[7:0];
				ADDR_GAIN:          core_gain       <= ev_data;
				ADDR_FORWARD_BYTE:  core_gain[15:8] <= ev_data[7:0];
				ADDR_FEEDBACK_BYTE: core_gain[7:0]  <= ev_data[7:0];
				default:            core_gain       <= core_gain;
			endcase
		end
	end

	// ==========================================================
	// decoded controls
	// ==========================================================
	// R1: power enables from bits
	// R2: forward path bit 7
	always_comb forward_path_enable = core_general[BIT_FWD_PWR];
	// R3: feedback and phase shifter
	always_comb feedback_path_enable = core_general[BIT_FEEDBACK_POWER_ENABLE];
	always_comb phase_shifter_enable = core_general[BIT_FEEDBACK_POWER_ENABLE];
	// R4: shared oscillator or
	always_comb local_osc_enable = core_general[BIT_FWD_PWR] | core_general[BIT_FEEDBACK_POWER_ENABLE];
	// R5: remaining block enables
	always_comb bias_enable       = core_general[BIT_BIAS_PWR];
	always_comb filter_amp_enable = core_general[BIT_FILT_PWR];
	always_comb input_amp_enable  = core_general[BIT_INAMP_PWR];
	always_comb error_amp_enable  = core_general[BIT_ERR_PWR];
	// R6: open loop select
	always_comb open_loop_mode = core_general[BIT_OPEN_LOOP];
	// R7: gain reduction resistor
	always_comb error_amp_gain_reduce = core_general[BIT_GAIN_RED];
	// R9: phase code steps 11.25 deg
	always_comb phase_shift_code = core_phase[PHASE_MSB:PHASE_LSB];
	// R12: forward code 2.5dB steps
	always_comb forward_atten_code = core_gain[FWD_MSB:FWD_LSB];
	// R14: feedback code passed raw
	always_comb feedback_atten_code = core_gain[FB_MSB:FB_LSB];
endmodule : ltc_regs

// ---- src/ltc_pkg.sv ----
package ltc_pkg;
	// serial addresses
	localparam logic [7:0] ADDR_RESET         = 8'h01;
	localparam logic [7:0] ADDR_GENERAL       = 8'h02;
	localparam logic [7:0] ADDR_PHASE         = 8'h03;
	localparam logic [7:0] ADDR_GAIN          = 8'h04;
	localparam logic [7:0] ADDR_FORWARD_BYTE  = 8'h05;
	localparam logic [7:0] ADDR_FEEDBACK_BYTE = 8'h06;
	localparam logic [7:0] ADDR_GENERAL_RB    = 8'hf2;
	localparam logic [7:0] ADDR_PHASE_RB      = 8'hf3;
	localparam logic [7:0] ADDR_GAIN_RB       = 8'hf4;
	localparam logic [7:0] ADDR_FORWARD_RB    = 8'hf5;
	localparam logic [7:0] ADDR_FEEDBACK_RB   = 8'hf6;
	// reset values
	localparam logic [7:0]  GENERAL_RESET = 8'h00;
	localparam logic [7:0]  PHASE_RESET   = 8'h00;
	localparam logic [15:0] GAIN_RESET    = 16'h0000;
	// general control field positions
	localparam int BIT_FWD_PWR   = 7;
	localparam int BIT_FEEDBACK_POWER_ENABLE    = 6;
	localparam int BIT_BIAS_PWR  = 5;
	localparam int BIT_FILT_PWR  = 4;
	localparam int BIT_INAMP_PWR = 3;
	localparam int BIT_ERR_PWR   = 2;
	localparam int BIT_OPEN_LOOP = 1;
	localparam int BIT_GAIN_RED  = 0;
	// phase and gain fields
	localparam int PHASE_MSB = 7;
	localparam int PHASE_LSB = 3;
	localparam int FWD_MSB   = 14;
	localparam int FWD_LSB   = 11;
	localparam int FB_MSB    = 5;
	localparam int FB_LSB    = 1;
endpackage : ltc_pkg

// ---- bench/ltc_host.sv ----
`timescale 1ns/100ps
// ==========================================
// host side of the serial control link
module ltc_host (
	output logic      serial_clk,
	output logic      chip_select_n,
	output logic      command_data_in,
	input  wire logic reply_line
);
	initial begin
		serial_clk = 1'b0;
		chip_select_n = 1'b1;
		command_data_in = 1'b0;
	end
	// address first, msb first, 80 ns bit time
	task automatic xfer(input logic [7:0] a, input int nb, input logic [15:0] d,
		output logic [15:0] r);
		logic [23:0] s;
		s = {a, d};
		r = 16'h0;
		chip_select_n = 1'b0;
		for (int i = 0; i < 8 + 8 * nb; i++) begin
			command_data_in = s[23 - i];
			#40 serial_clk = 1'b1;
			r = {r[14:0], reply_line};
			#40 serial_clk = 1'b0;
		end
		// clock stands still and data flips, so stale bits never look valid
		#40 chip_select_n = 1'b1;
		command_data_in = ~command_data_in;
	endtask : xfer
endmodule : ltc_host

// ---- bench/ltc_regs_asserts.sv ----
`timescale 1ns/100ps
// ==========================================
// port checker for the control registers
module ltc_regs_chk (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       chip_select_n,
	input wire logic       reply_data_oe,
	input wire logic       forward_path_enable,
	input wire logic       feedback_path_enable,
	input wire logic       phase_shifter_enable,
	input wire logic       local_osc_enable,
	input wire logic [4:0] phase_shift_code
);
	logic [3:0] gap;
	wire logic [6:0] ctl = {forward_path_enable, feedback_path_enable, phase_shift_code};
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// core cycles since select was last low, saturating
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			gap <= 4'h0;
		else if (!chip_select_n)
			gap <= 4'h0;
		else if (gap != 4'hf)
			gap <= gap + 4'h1;
	end
	// eight idle cycles lie past any pending commit
	sequence s_idle;
		chip_select_n [*8];
	endsequence
	sequence s_deselect;
		chip_select_n [*2];
	endsequence
	a_osc_either_path: assert property (local_osc_enable == (forward_path_enable | feedback_path_enable))
		else $error("oscillator enable not or of path enables");
	a_shifter_with_fb: assert property (phase_shifter_enable == feedback_path_enable)
		else $error("phase shifter enable differs from feedback");
	a_reset_clears: assert property ($fell(rst) |-> ctl == 7'h0 && !local_osc_enable)
		else $error("outputs not clear after reset");
	a_idle_settled: assert property (s_idle |-> $stable(ctl))
		else $error("control outputs moved while link idle");
	a_change_near_frame: assert property ($changed(ctl) |-> gap < 4'd10)
		else $error("control outputs moved far from any frame");
	a_oe_framed: assert property (s_deselect |-> !reply_data_oe)
		else $error("reply driven while deselected");
	a_oe_after_addr: assert property ($rose(reply_data_oe) |-> $past(chip_select_n, 28) == 1'b0)
		else $error("reply driven before address byte");
	a_oe_holds: assert property (reply_data_oe && !chip_select_n |=> reply_data_oe || chip_select_n)
		else $error("reply enable dropped inside frame");
endmodule : ltc_regs_chk
bind ltc_regs ltc_regs_chk u_chk (.clk, .rst, .chip_select_n, .reply_data_oe,
	.forward_path_enable, .feedback_path_enable, .phase_shifter_enable,
	.local_osc_enable, .phase_shift_code);

// ---- bench/tb_ltc_regs.sv ----
`timescale 1ns/100ps
// ==========================================
// bench for the control registers
module tb_ltc_regs;
	import ltc_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        serial_clk, chip_select_n, command_data_in, reply_data_out, reply_data_oe;
	logic [9:0]  en;
	logic [4:0]  ph, fb;
	logic [3:0]  fa;
	logic [7:0]  g, p;
	logic [15:0] w, r;
	logic [23:0] exp_q[$];
	logic [23:0] seen, e;
	string       what;
	int          error_cnt = 0;
	int          compares = 0;
	event        res_ev;
	// undriven reply line reads high through its pull-up
	wire logic reply_line = reply_data_oe ? reply_data_out : 1'b1;
	always #10 clk = ~clk;
	ltc_host u_host (.serial_clk(serial_clk), .chip_select_n(chip_select_n),
		.command_data_in(command_data_in), .reply_line(reply_line));
	ltc_regs u_dut (.clk(clk), .rst(rst), .serial_clk(serial_clk),
		.chip_select_n(chip_select_n), .command_data_in(command_data_in),
		.reply_data_out(reply_data_out), .reply_data_oe(reply_data_oe),
		.forward_path_enable(en[9]), .feedback_path_enable(en[8]),
		.phase_shifter_enable(en[7]), .local_osc_enable(en[6]), .bias_enable(en[5]),
		.filter_amp_enable(en[4]), .input_amp_enable(en[3]), .error_amp_enable(en[2]),
		.open_loop_mode(en[1]), .error_amp_gain_reduce(en[0]), .phase_shift_code(ph),
		.forward_atten_code(fa), .feedback_atten_code(fb));
	// watcher: oldest note against each observed result
	always @(res_ev) begin
		e = exp_q.pop_front();
		compares++;
		if (e !== seen) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, e, seen);
		end
	end
	task automatic note(input string n, input logic [23:0] x, input logic [23:0] v);
		exp_q.push_back(x);
		what = n;
		seen = v;
		->res_ev;
		#1;
	endtask : note
	// one frame, which commits before chip select rises, then ten idle core cycles; the read-back copy moves only on serial_clk
	task automatic op(input logic [7:0] a, input int nb, input logic [15:0] d);
		@(negedge clk);
		u_host.xfer(a, nb, d, r);
		repeat (10) @(posedge clk);
	endtask : op
	task automatic check_all();
		logic [15:0] rb[5];
		rb = '{g, p, w, w[15:8], w[7:0]};
		note("outputs", {g[7], g[6], g[6], g[7] | g[6], g[5:0], p[7:3], w[14:11], w[5:1]},
			{en, ph, fa, fb});
		for (int k = 0; k < 5; k++) begin
			op(8'(ADDR_GENERAL_RB + k), (k == 2) ? 2 : 1, 16'h0);
			note("readback", {8'h0, rb[k]}, {8'h0, (k == 2) ? r : {8'h0, r[7:0]}});
		end
	endtask : check_all
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict
	initial begin
		void'($urandom(32'h70050dca));
		{g, p, w} = 32'h0;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		repeat (2) @(posedge clk);
		check_all();
		$display("reset pin test done");
		for (int i = 0; i < 8; i++) begin
			g = 8'($urandom);
			p = 8'($urandom) & 8'hf8;
			w = 16'($urandom) & 16'h783e;
			op(ADDR_GENERAL, 1, {g, 8'h0});
			op(ADDR_PHASE, 1, {p, 8'h0});
			op(ADDR_GAIN, 2, w);
			check_all();
		end
		$display("random write test done");
		// byte halves with reserved bits zero except forward byte bit 7, which stays random
		w = {8'($urandom) & 8'hf8, 8'($urandom) & 8'h3e};
		op(ADDR_FORWARD_BYTE, 1, {w[15:8], 8'h0});
		op(ADDR_FEEDBACK_BYTE, 1, {w[7:0], 8'h0});
		op(ADDR_GAIN, 1, 16'hffff);
		op(8'h09, 1, 16'hffff);
		check_all();
		$display("alias and refusal test done");
		// pin reset in mid-run clears like the command
		@(negedge clk);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		{g, p, w} = 32'h0;
		repeat (2) @(posedge clk);
		check_all();
		$display("mid-run reset test done");
		// refill so the reset command has work to do
		g = 8'($urandom);
		p = 8'($urandom) & 8'hf8;
		w = 16'($urandom) & 16'h783e;
		op(ADDR_GENERAL, 1, {g, 8'h0});
		op(ADDR_PHASE, 1, {p, 8'h0});
		op(ADDR_GAIN, 2, w);
		op(ADDR_RESET, 0, 16'h0);
		{g, p, w} = 32'h0;
		check_all();
		$display("reset command test done");
		give_verdict();
	end
	initial begin
		#1000000;
		error_cnt++;
		$display("[FAIL] run time expected done seen hung");
		give_verdict();
	end
endmodule : tb_ltc_regs
